// ### inc/scsa_defs.svh
// Register offsets, field positions, reset values and timing figures of the suspend block.
`ifndef SCSA_DEFS_SVH
`define SCSA_DEFS_SVH

`define SCSA_ADDR_TEN       16'h8504
`define SCSA_ADDR_CSTP      16'h8508
`define SCSA_ADDR_STATUS    16'h850c
`define SCSA_ADDR_BASE      16'h8510
`define SCSA_ADDR_MASK      16'h8514
`define SCSA_ADDR_IRQ_STAT  16'h8520
`define SCSA_ADDR_IRQ_CLR   16'h8524
`define SCSA_ADDR_IRQ_EN    16'h8528

`define SCSA_ST_VIDEO       7
`define SCSA_ST_CACHE       6
`define SCSA_ST_RANGE       1
`define SCSA_ST_USED        8'hc2

`define SCSA_TEN_CPU_EN     1
`define SCSA_TEN_CPU_RD     2
`define SCSA_TEN_FREQ_LO    3
`define SCSA_TEN_FREQ_HI    4
`define SCSA_TEN_WMASK      32'h0000001f
`define SCSA_CSTP_HALT      0
`define SCSA_CSTP_WMASK     32'h00000001
`define SCSA_MASK_RE        0
`define SCSA_MASK_WE        1
`define SCSA_ADDR_LO        2
`define SCSA_ADDR_HI        27
`define SCSA_BASE_WMASK     32'h0ffffffc
`define SCSA_MASK_WMASK     32'h0fffffff
`define SCSA_IRQ_WMASK      32'h0000000f

`define SCSA_IRQ_VIDEO      0
`define SCSA_IRQ_CACHE      1
`define SCSA_IRQ_RANGE      2
`define SCSA_IRQ_PACKET     3

`define SCSA_RST_REG        32'h00000000
`define SCSA_RST_STATUS     8'h00
`define SCSA_RST_IRQ        4'h0

`define SCSA_FREQ_OFF       2'b00
`define SCSA_FREQ_1         2'b01
`define SCSA_FREQ_5         2'b10
`define SCSA_FREQ_10        2'b11

`define SCSA_RESP_OKAY      2'b00
`define SCSA_RESP_SLVERR    2'b10

`define SCSA_CLK_MHZ        250
`define SCSA_INT1_US        1000
`define SCSA_INT5_US        5000
`define SCSA_INT10_US       10000

`endif

// ### inc/scsa_pkg.sv
// Types shared by the suspend and activity status block.
package scsa_pkg;

	typedef struct packed {
		logic [15:0] awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [15:0] araddr;
		logic        arvalid;
		logic        rready;
	} scsa_axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} scsa_axil_rsp_t;

	typedef enum logic {SCSA_RUN, SCSA_SUSPEND_REQUEST_N} scsa_suspend_request_n_state_t;

endpackage

// ### hw/scsa_range_match.sv
// Programmable memory range compare with per-bit mask and cycle type gating.
`timescale 1ns/10ps
`default_nettype none
module scsa_range_match #(
	parameter int unsigned AW = 26
) (
	input  wire logic [AW-1:0] base,
	input  wire logic [AW-1:0] mask,
	input  wire logic [AW-1:0] addr,
	input  wire logic          access_valid,
	input  wire logic          access_write,
	input  wire logic          read_enable,
	input  wire logic          write_enable,
	output logic               hit
);
	if (AW < 1 || AW > 30) begin : g_bad_aw
		$error("scsa_range_match: AW must lie in 1..30");
	end

	logic [AW-1:0] bit_ok;
	logic          type_ok;

	// A set mask bit makes that position always compare, so any base is usable.
	for (genvar i = 0; i < AW; i++) begin : g_bit
		assign bit_ok[i] = mask[i] | ~(base[i] ^ addr[i]);
	end

	// Only the enabled cycle types may report a hit.
	assign type_ok = access_write ? write_enable : read_enable;
	assign hit     = access_valid & type_ok & (&bit_ok);
endmodule // scsa_range_match
`default_nettype wire

// ### hw/scsa_suspend_ctl.sv
// Suspend request and acknowledge handshake with clock-stop mode selection.
`timescale 1ns/10ps
`default_nettype none
module scsa_suspend_ctl
	import scsa_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic arst_n,
	input  wire logic suspend_request_n,
	input  wire logic clock_halt_select,
	output logic      suspend_ack_n,
	output logic      mem_clk_en,
	output logic      disp_clk_en,
	output logic      system_clock_in_stop_ok
);
	logic             req_meta;
	logic             req_sync;
	scsa_suspend_request_n_state_t state;
	scsa_suspend_request_n_state_t next_state;
	logic             halt_mode;
	logic             next_halt_mode;
	logic             next_ack_n;
	logic             next_clk_en;
	logic             next_stop_ok;

	// The pin is asynchronous, so it passes two flops before the state logic sees it.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			req_meta <= 1'b0;
			req_sync <= 1'b0;
		end else begin
			req_meta <= ~suspend_request_n;
			req_sync <= req_meta;
		end
	end

	// The mode is frozen at entry so a change in suspend cannot stop clocks late.
	always_comb begin
		next_state     = state;
		next_halt_mode = halt_mode;
		case (state)
			SCSA_RUN: begin
				next_halt_mode = clock_halt_select;
				if (req_sync) begin
					next_state = SCSA_SUSPEND_REQUEST_N;
				end
			end
			SCSA_SUSPEND_REQUEST_N: begin
				if (!req_sync) begin
					next_state = SCSA_RUN;
				end
			end
			default: begin
				next_state = SCSA_RUN;
			end
		endcase
		next_ack_n   = (next_state != SCSA_SUSPEND_REQUEST_N);
		next_stop_ok = (next_state == SCSA_SUSPEND_REQUEST_N) && next_halt_mode;
		next_clk_en  = !next_stop_ok;
	end

	// Outputs are registered so the acknowledge never glitches at the pin.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state          <= SCSA_RUN;
			halt_mode      <= 1'b0;
			suspend_ack_n  <= 1'b1;
			mem_clk_en     <= 1'b1;
			disp_clk_en    <= 1'b1;
			system_clock_in_stop_ok <= 1'b0;
		end else begin
			state          <= next_state;
			halt_mode      <= next_halt_mode;
			suspend_ack_n  <= next_ack_n;
			mem_clk_en     <= next_clk_en;
			disp_clk_en    <= next_clk_en;
			system_clock_in_stop_ok <= next_stop_ok;
		end
	end
endmodule // scsa_suspend_ctl
`default_nettype wire

// ### hw/scsa_top.sv
// Suspend handshake, activity status snapshot, packet pacing and AXI4-Lite registers.
`timescale 1ns/10ps
`default_nettype none
`include "scsa_defs.svh"
module scsa_top #(
	parameter int unsigned CYC_1MS  = `SCSA_INT1_US * `SCSA_CLK_MHZ,
	parameter int unsigned CYC_5MS  = `SCSA_INT5_US * `SCSA_CLK_MHZ,
	parameter int unsigned CYC_10MS = `SCSA_INT10_US * `SCSA_CLK_MHZ
) (
	input  wire logic                    clk_sys,
	input  wire logic                    arst_n,
	input  wire scsa_pkg::scsa_axil_req_t axil_req,
	output scsa_pkg::scsa_axil_rsp_t     axil_rsp,
	input  wire logic                    suspend_request_n,
	output logic                         suspend_ack_n,
	output logic                         mem_clk_en,
	output logic                         disp_clk_en,
	output logic                         system_clock_in_stop_ok,
	input  wire logic                    vertical_interrupt_flag,
	input  wire logic                    miss_valid,
	input  wire logic                    miss_ifetch,
	input  wire logic                    miss_write,
	input  wire logic                    mem_valid,
	input  wire logic                    mem_write,
	input  wire logic [31:0]             mem_addr,
	output logic                         packet_strobe,
	output logic [7:0]                   packet_data,
	output logic                         irq
);
	import scsa_pkg::*;

	if (CYC_1MS < 2 || CYC_5MS < 2 || CYC_10MS < 2) begin : g_bad_cyc
		$error("scsa_top: interval counts must be at least 2 cycles");
	end

	localparam int AHI = `SCSA_ADDR_HI;
	localparam int ALO = `SCSA_ADDR_LO;

	logic [31:0] transmit_enable_control;
	logic [31:0] clock_halt_cfg;
	logic [31:0] range_base;
	logic [31:0] range_mask;
	logic [7:0]  serial_packet_status;
	logic [3:0]  irq_status;
	logic [3:0]  irq_enable;
	logic [31:0] next_ten;
	logic [31:0] next_cstp;
	logic [31:0] next_base;
	logic [31:0] next_mask;
	logic [7:0]  next_status;
	logic [3:0]  next_irq_status;
	logic [3:0]  next_irq_enable;
	logic [3:0]  irq_clear;
	logic        aw_held;
	logic        w_held;
	logic [15:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        next_aw_held;
	logic        next_w_held;
	logic [15:0] next_aw_addr;
	logic [31:0] next_w_data;
	logic [3:0]  next_w_strb;
	logic        bvalid;
	logic [1:0]  bresp;
	logic        next_bvalid;
	logic [1:0]  next_bresp;
	logic        rvalid;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0]  next_rresp;
	logic        rd_status;
	logic        next_rd_status;
	logic        do_write;
	logic        range_hit;
	logic        video_set;
	logic        cache_set;
	logic [7:0]  status_set;
	logic [31:0] interval_cnt;
	logic [31:0] next_interval_cnt;
	logic [31:0] interval_len;
	logic        send_now;
	logic        next_packet_strobe;
	logic [7:0]  next_packet_data;
	logic [1:0]  freq_sel;

	// Byte strobes select which lanes of a writable register take new data.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
			input logic [3:0] strb, input logic [31:0] wmask);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = val[b*8 +: 8];
			end
		end
		return res & wmask;
	endfunction

	scsa_suspend_ctl u_suspend (
		.clk_sys           (clk_sys),
		.arst_n            (arst_n),
		.suspend_request_n (suspend_request_n),
		.clock_halt_select (clock_halt_cfg[`SCSA_CSTP_HALT]),
		.suspend_ack_n     (suspend_ack_n),
		.mem_clk_en        (mem_clk_en),
		.disp_clk_en       (disp_clk_en),
		.system_clock_in_stop_ok    (system_clock_in_stop_ok)
	);

	scsa_range_match #(.AW(AHI - ALO + 1)) u_range (
		.base         (range_base[AHI:ALO]),
		.mask         (range_mask[AHI:ALO]),
		.addr         (mem_addr[AHI:ALO]),
		.access_valid (mem_valid),
		.access_write (mem_write),
		.read_enable  (range_mask[`SCSA_MASK_RE]),
		.write_enable (range_mask[`SCSA_MASK_WE]),
		.hit          (range_hit)
	);

	// Event sources feeding the status snapshot.
	assign video_set = vertical_interrupt_flag;
	assign cache_set = miss_valid && !miss_ifetch && transmit_enable_control[`SCSA_TEN_CPU_EN]
		&& (miss_write || transmit_enable_control[`SCSA_TEN_CPU_RD]);
	assign status_set = {video_set, cache_set, 4'h0, range_hit, 1'b0} & `SCSA_ST_USED;

	// Interval pacing: a packet goes out only once something has accumulated.
	assign freq_sel = transmit_enable_control[`SCSA_TEN_FREQ_HI:`SCSA_TEN_FREQ_LO];
	always_comb begin
		case (freq_sel)
			`SCSA_FREQ_1:  interval_len = CYC_1MS;
			`SCSA_FREQ_5:  interval_len = CYC_5MS;
			`SCSA_FREQ_10: interval_len = CYC_10MS;
			default:       interval_len = 32'h00000000;
		endcase
		send_now          = 1'b0;
		next_interval_cnt = interval_cnt;
		if (freq_sel == `SCSA_FREQ_OFF) begin
			next_interval_cnt = 32'h00000000;
		end else if (interval_cnt >= interval_len - 32'h00000001) begin
			if (serial_packet_status != `SCSA_RST_STATUS) begin
				send_now          = 1'b1;
				next_interval_cnt = 32'h00000000;
			end
		end else begin
			next_interval_cnt = interval_cnt + 32'h00000001;
		end
		next_packet_strobe = send_now;
		next_packet_data   = send_now ? serial_packet_status : packet_data;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			interval_cnt  <= 32'h00000000;
			packet_strobe <= 1'b0;
			packet_data   <= `SCSA_RST_STATUS;
		end else begin
			interval_cnt  <= next_interval_cnt;
			packet_strobe <= next_packet_strobe;
			packet_data   <= next_packet_data;
		end
	end

	// Bus handshake: address and data are taken in either order, answered together.
	assign axil_rsp.awready = !aw_held && !bvalid;
	assign axil_rsp.wready  = !w_held && !bvalid;
	assign axil_rsp.arready = !rvalid;
	assign axil_rsp.bvalid  = bvalid;
	assign axil_rsp.bresp   = bresp;
	assign axil_rsp.rvalid  = rvalid;
	assign axil_rsp.rdata   = rdata;
	assign axil_rsp.rresp   = rresp;
	assign do_write = aw_held && w_held && !bvalid;

	// Register file next state; hardware sets win over any clear in the same cycle.
	always_comb begin
		next_aw_held    = aw_held;
		next_w_held     = w_held;
		next_aw_addr    = aw_addr;
		next_w_data     = w_data;
		next_w_strb     = w_strb;
		next_bvalid     = bvalid;
		next_bresp      = bresp;
		next_ten        = transmit_enable_control;
		next_cstp       = clock_halt_cfg;
		next_base       = range_base;
		next_mask       = range_mask;
		next_irq_enable = irq_enable;
		irq_clear       = 4'h0;
		if (axil_req.awvalid && axil_rsp.awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = axil_req.awaddr;
		end
		if (axil_req.wvalid && axil_rsp.wready) begin
			next_w_held = 1'b1;
			next_w_data = axil_req.wdata;
			next_w_strb = axil_req.wstrb;
		end
		if (bvalid && axil_req.bready) begin
			next_bvalid = 1'b0;
		end
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = `SCSA_RESP_OKAY;
			case ({aw_addr[15:2], 2'b00})
				`SCSA_ADDR_TEN:    next_ten  = merge(transmit_enable_control, w_data, w_strb,
					`SCSA_TEN_WMASK);
				`SCSA_ADDR_CSTP:   next_cstp = merge(clock_halt_cfg, w_data, w_strb,
					`SCSA_CSTP_WMASK);
				`SCSA_ADDR_BASE:   next_base = merge(range_base, w_data, w_strb,
					`SCSA_BASE_WMASK);
				`SCSA_ADDR_MASK:   next_mask = merge(range_mask, w_data, w_strb,
					`SCSA_MASK_WMASK);
				`SCSA_ADDR_IRQ_EN: next_irq_enable = 4'(merge(32'(irq_enable), w_data,
					w_strb, `SCSA_IRQ_WMASK));
				`SCSA_ADDR_IRQ_CLR: irq_clear = 4'(merge(32'h0, w_data, w_strb,
					`SCSA_IRQ_WMASK));
				default:           next_bresp = `SCSA_RESP_SLVERR;
			endcase
		end
		next_status = (send_now ? `SCSA_RST_STATUS : serial_packet_status) | status_set;
		next_irq_status = (irq_status & ~irq_clear)
			| {send_now, range_hit, cache_set, video_set};
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			aw_held                 <= 1'b0;
			w_held                  <= 1'b0;
			aw_addr                 <= 16'h0000;
			w_data                  <= 32'h00000000;
			w_strb                  <= 4'h0;
			bvalid                  <= 1'b0;
			bresp                   <= `SCSA_RESP_OKAY;
			transmit_enable_control <= `SCSA_RST_REG;
			clock_halt_cfg          <= `SCSA_RST_REG;
			range_base              <= `SCSA_RST_REG;
			range_mask              <= `SCSA_RST_REG;
			irq_enable              <= `SCSA_RST_IRQ;
			irq_status              <= `SCSA_RST_IRQ;
			serial_packet_status    <= `SCSA_RST_STATUS;
		end else begin
			aw_held                 <= next_aw_held;
			w_held                  <= next_w_held;
			aw_addr                 <= next_aw_addr;
			w_data                  <= next_w_data;
			w_strb                  <= next_w_strb;
			bvalid                  <= next_bvalid;
			bresp                   <= next_bresp;
			transmit_enable_control <= next_ten;
			clock_halt_cfg          <= next_cstp;
			range_base              <= next_base;
			range_mask              <= next_mask;
			irq_enable              <= next_irq_enable;
			irq_status              <= next_irq_status;
			serial_packet_status    <= next_status;
		end
	end

	// Read channel; the upper status bits are simply not stored, so they read zero.
	always_comb begin
		next_rvalid    = rvalid;
		next_rdata     = rdata;
		next_rresp     = rresp;
		next_rd_status = rd_status;
		if (rvalid && axil_req.rready) begin
			next_rvalid = 1'b0;
		end
		if (axil_req.arvalid && axil_rsp.arready) begin
			next_rvalid    = 1'b1;
			next_rresp     = `SCSA_RESP_OKAY;
			next_rd_status = 1'b0;
			case ({axil_req.araddr[15:2], 2'b00})
				`SCSA_ADDR_TEN:      next_rdata = transmit_enable_control;
				`SCSA_ADDR_CSTP:     next_rdata = clock_halt_cfg;
				`SCSA_ADDR_STATUS: begin
					next_rdata     = {24'h000000, serial_packet_status};
					next_rd_status = 1'b1;
				end
				`SCSA_ADDR_BASE:     next_rdata = range_base;
				`SCSA_ADDR_MASK:     next_rdata = range_mask;
				`SCSA_ADDR_IRQ_STAT: next_rdata = {28'h0000000, irq_status};
				`SCSA_ADDR_IRQ_EN:   next_rdata = {28'h0000000, irq_enable};
				default: begin
					next_rdata = 32'h00000000;
					next_rresp = `SCSA_RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rvalid    <= 1'b0;
			rdata     <= 32'h00000000;
			rresp     <= `SCSA_RESP_OKAY;
			rd_status <= 1'b0;
			irq       <= 1'b0;
		end else begin
			rvalid    <= next_rvalid;
			rdata     <= next_rdata;
			rresp     <= next_rresp;
			rd_status <= next_rd_status;
			irq       <= |(next_irq_status & next_irq_enable);
		end
	end

	// Checks on the observable behaviour of the block.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	AST_ACK_AFTER_REQ: assert property (!suspend_request_n [*4] |-> !suspend_ack_n)
		else $error("acknowledge missing after held suspend request");
	AST_REFRESH_CLOCKS: assert property (!system_clock_in_stop_ok |-> mem_clk_en && disp_clk_en)
		else $error("clocks gated outside clock-stop suspend");
	AST_STOP_NEEDS_ACK: assert property (system_clock_in_stop_ok |-> !suspend_ack_n
		&& !mem_clk_en)
		else $error("clock stop allowed without acknowledge");
	AST_VIDEO_SETS: assert property (vertical_interrupt_flag |=>
		serial_packet_status[`SCSA_ST_VIDEO])
		else $error("video sync not recorded");
	AST_MISS_SETS: assert property (miss_valid && !miss_ifetch && miss_write
		&& transmit_enable_control[`SCSA_TEN_CPU_EN] |=>
		serial_packet_status[`SCSA_ST_CACHE])
		else $error("enabled cache miss not recorded");
	AST_MISS_GATED: assert property ($rose(serial_packet_status[`SCSA_ST_CACHE]) |->
		$past(miss_valid && !miss_ifetch && transmit_enable_control[`SCSA_TEN_CPU_EN]))
		else $error("cache activity recorded without enabled miss");
	AST_RESERVED_ZERO: assert property (rvalid && rd_status |-> rdata[31:8] == 24'h000000
		&& rdata[5:2] == 4'h0)
		else $error("reserved status bits not zero");
	AST_RANGE_READ: assert property (mem_valid && !mem_write && range_mask[`SCSA_MASK_RE]
		&& ((mem_addr[AHI:ALO] ^ range_base[AHI:ALO]) & ~range_mask[AHI:ALO]) == 26'h0
		|=> serial_packet_status[`SCSA_ST_RANGE])
		else $error("range hit not recorded");
	AST_INTERVAL_OFF: assert property (packet_strobe |-> $past(freq_sel) != `SCSA_FREQ_OFF)
		else $error("packet sent with transmitter disabled");
	AST_SEND_CLEARS: assert property (packet_strobe && $past(status_set) == 8'h00 |->
		serial_packet_status == `SCSA_RST_STATUS && packet_data != 8'h00)
		else $error("status not cleared after packet");

	COV_HALT_SUSPEND: cover property (system_clock_in_stop_ok);
	COV_REFRESH_SUSPEND: cover property (!suspend_ack_n && mem_clk_en);
	COV_PACKET_SENT: cover property (packet_strobe && packet_data[`SCSA_ST_RANGE]);
	COV_IRQ: cover property ($rose(irq));
endmodule // scsa_top
`default_nettype wire

// ### verif/scsa_pm_model.sv
// Behavioural power manager that asks for suspend and may halt the system clock.
`timescale 1ns/10ps
`default_nettype none
module scsa_pm_model (
	input  wire logic clk_sys,
	input  wire logic suspend_ack_n,
	input  wire logic go,
	input  wire logic halt_mode,
	output logic      suspend_request_n,
	output logic      clk_hold,
	output logic      in_suspend_request_n,
	output logic      fault
);
	int n;
	// One handshake per rise of go; a wait that runs out raises fault.
	initial begin
		suspend_request_n = 1'b1;
		clk_hold = 1'b0;
		in_suspend_request_n = 1'b0;
		fault = 1'b0;
		forever begin
			@(posedge go);
			@(posedge clk_sys);
			suspend_request_n <= 1'b0;
			for (n = 0; n < 20 && suspend_ack_n !== 1'b0; n++) @(negedge clk_sys);
			fault |= (n == 20);
			in_suspend_request_n = 1'b1;
			repeat (4) @(posedge clk_sys);
			// Stopping only after acknowledge, or never in refresh mode, protects the memory.
			if (halt_mode) begin
				@(negedge clk_sys);
				clk_hold = 1'b1;
				#39 clk_hold = 1'b0;
				repeat (2) @(posedge clk_sys);
			end
			wait (go == 1'b0);
			@(posedge clk_sys);
			in_suspend_request_n = 1'b0;
			suspend_request_n <= 1'b1;
			for (n = 0; n < 20 && suspend_ack_n !== 1'b1; n++) @(negedge clk_sys);
			fault |= (n == 20);
		end
	end
endmodule // scsa_pm_model
`default_nettype wire

// ### verif/scsa_top_test.sv
// Self-checking bench for the suspend and activity status block.
`timescale 1ns/10ps
`default_nettype none
`include "scsa_defs.svh"
module scsa_top_test;
	import scsa_pkg::*;
	localparam logic [1:0] OK = `SCSA_RESP_OKAY;
	localparam logic [1:0] SE = `SCSA_RESP_SLVERR;
	logic           clk_sys, arst_n, go, halt_mode, clk_hold, in_suspend_request_n, fault, pk_on;
	logic           suspend_request_n, suspend_ack_n, mem_clk_en, disp_clk_en, system_clock_in_stop_ok;
	logic           packet_strobe, irq;
	logic [5:0]     evs;
	logic [31:0]    mem_addr, base, near;
	logic [7:0]     packet_data;
	scsa_axil_req_t rq;
	scsa_axil_rsp_t rs;
	logic [33:0]    rdq[$];
	logic [1:0]     bq[$];
	logic [7:0]     pq[$];
	logic [5:0]     ds[3] = '{6'h18, 6'h02, 6'h03};
	logic [5:0]     ef[3] = '{6'h20, 6'h10, 6'h02};
	logic [7:0]     ex[3] = '{8'h80, 8'h40, 8'h02};
	int             iv[4] = '{0, 20, 50, 100};
	int             err_count, compares, pk_cnt, cyc, t0, k, c;

	scsa_top #(.CYC_1MS(20), .CYC_5MS(50), .CYC_10MS(100)) scsa_top_i (
		.clk_sys(clk_sys), .arst_n(arst_n), .axil_req(rq), .axil_rsp(rs),
		.suspend_request_n(suspend_request_n), .suspend_ack_n(suspend_ack_n),
		.mem_clk_en(mem_clk_en), .disp_clk_en(disp_clk_en), .system_clock_in_stop_ok(system_clock_in_stop_ok),
		.vertical_interrupt_flag(evs[5]), .miss_valid(evs[4]), .miss_ifetch(evs[3]),
		.miss_write(evs[2]), .mem_valid(evs[1]), .mem_write(evs[0]), .mem_addr(mem_addr),
		.packet_strobe(packet_strobe), .packet_data(packet_data), .irq(irq));
	scsa_pm_model scsa_pm_model_i (
		.clk_sys(clk_sys), .suspend_ack_n(suspend_ack_n), .go(go), .halt_mode(halt_mode),
		.suspend_request_n(suspend_request_n), .clk_hold(clk_hold), .in_suspend_request_n(in_suspend_request_n),
		.fault(fault));

	// The clock halts low while the power manager holds it.
	initial begin
		clk_sys = 1'b0;
		forever begin
			#2;
			if (!clk_hold) clk_sys = ~clk_sys;
		end
	end

	// Results are compared in arrival order against the notes the drivers left.
	always @(posedge clk_sys) begin
		cyc++;
		if (rs.rvalid && rq.rready) chk("rdata", rdq.pop_front(), {rs.rresp, rs.rdata});
		if (rs.bvalid && rq.bready) chk("bresp", 34'(bq.pop_front()), 34'(rs.bresp));
		if (packet_strobe === 1'b1) pk_cnt++;
		if (packet_strobe === 1'b1 && pk_on) chk("packet", 34'(pq.pop_front()), 34'(packet_data));
	end

	task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
		compares++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic to(input bit bad);
		if (bad) begin
			chk("wait", 34'h0, 34'h1);
			report_and_stop();
		end
	endtask
	function automatic logic hi(input int w);
		return w == 0 ? rs.arready : w == 1 ? rs.rvalid : rs.bvalid;
	endfunction
	// Ready is looked at on the falling edge, so the transfer is taken on the next rising one.
	task automatic wait_hi(input int w);
		int n;
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (n < 50 && hi(w) !== 1'b1);
		to(n == 50);
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r);
		logic pa, pw, ta, tw;
		int n;
		bq.push_back(r);
		@(posedge clk_sys);
		rq.awaddr <= a;
		rq.wdata <= d;
		rq.awvalid <= 1'b1;
		rq.wvalid <= 1'b1;
		rq.bready <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		for (n = 0; n < 50 && (pa || pw); n++) begin
			@(negedge clk_sys);
			ta = pa && rs.awready;
			tw = pw && rs.wready;
			@(posedge clk_sys);
			if (ta) rq.awvalid <= 1'b0;
			if (tw) rq.wvalid <= 1'b0;
			pa = pa && !ta;
			pw = pw && !tw;
		end
		to(n == 50);
		wait_hi(2);
		rq.bready <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r);
		rdq.push_back({r, d});
		@(posedge clk_sys);
		rq.araddr <= a;
		rq.arvalid <= 1'b1;
		rq.rready <= 1'b1;
		wait_hi(0);
		rq.arvalid <= 1'b0;
		wait_hi(1);
		rq.rready <= 1'b0;
	endtask
	task automatic ev(input logic [5:0] f, input logic [31:0] a);
		@(posedge clk_sys);
		evs <= f;
		mem_addr <= a;
		@(posedge clk_sys);
		evs <= 6'h00;
	endtask
	task automatic wait_pk();
		int n;
		c = pk_cnt;
		for (n = 0; n < 150 && pk_cnt == c; n++) @(negedge clk_sys);
		to(n == 150);
	endtask
	task automatic lvl(input logic e);
		repeat (3) @(negedge clk_sys);
		chk("irq", 34'(e), 34'(irq));
	endtask

	initial begin
		arst_n = 1'b0;
		go = 1'b0;
		halt_mode = 1'b0;
		pk_on = 1'b0;
		evs = 6'h00;
		mem_addr = 32'h0;
		rq = '0;
		rq.wstrb = 4'hf;
		void'($urandom(32'h08d7));
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		rd(`SCSA_ADDR_STATUS, 32'h0, OK);
		wr(`SCSA_ADDR_STATUS, 32'hffffffff, SE);
		rd(`SCSA_ADDR_STATUS, 32'h0, OK);
		rd(16'h8600, 32'h0, SE);
		wr(`SCSA_ADDR_TEN, 32'hffffffff, OK);
		rd(`SCSA_ADDR_TEN, `SCSA_TEN_WMASK, OK);
		base = $urandom & `SCSA_BASE_WMASK;
		wr(`SCSA_ADDR_BASE, base, OK);
		rd(`SCSA_ADDR_BASE, base, OK);
		// Only byte lane 0 may take the new value; the other lanes keep the old base.
		rq.wstrb <= 4'h1;
		wr(`SCSA_ADDR_BASE, ~base, OK);
		base = (base & 32'h0fffff00) | (~base & 32'h000000fc);
		rd(`SCSA_ADDR_BASE, base, OK);
		rq.wstrb <= 4'hf;
		$display("test registers done");
		wr(`SCSA_ADDR_TEN, 32'h0, OK);
		wr(`SCSA_ADDR_IRQ_CLR, 32'hf, OK);
		wr(`SCSA_ADDR_IRQ_EN, 32'h1, OK);
		ev(6'h20, 32'h0);
		lvl(1'b1);
		wr(`SCSA_ADDR_IRQ_EN, 32'h0, OK);
		lvl(1'b0);
		rd(`SCSA_ADDR_IRQ_STAT, 32'h1, OK);
		wr(`SCSA_ADDR_IRQ_EN, 32'h1, OK);
		lvl(1'b1);
		wr(`SCSA_ADDR_IRQ_CLR, 32'h1, OK);
		lvl(1'b0);
		rd(`SCSA_ADDR_IRQ_STAT, 32'h0, OK);
		$display("test interrupt done");
		// Each packet must carry only its event, never the distractor before it.
		wr(`SCSA_ADDR_MASK, 32'h3d, OK);
		wr(`SCSA_ADDR_TEN, 32'h0e, OK);
		pk_on = 1'b1;
		pq.push_back(8'h80);
		wait_pk();
		for (k = 0; k < 3; k++) begin
			near = base | ($urandom & 32'h3c);
			pq.push_back(ex[k]);
			ev(ds[k], k == 1 ? base ^ 32'h00100000 : near);
			ev(ef[k], near);
			wait_pk();
		end
		wr(`SCSA_ADDR_TEN, 32'h08, OK);
		pq.push_back(8'h80);
		ev(6'h10, 32'h0);
		ev(6'h20, 32'h0);
		wait_pk();
		wr(`SCSA_ADDR_TEN, 32'h0a, OK);
		pq.push_back(8'h40);
		ev(6'h10, 32'h0);
		ev(6'h14, 32'h0);
		wait_pk();
		rd(`SCSA_ADDR_STATUS, 32'h0, OK);
		$display("test events done");
		pk_on = 1'b0;
		@(posedge clk_sys);
		evs <= 6'h20;
		for (k = 1; k < 4; k++) begin
			wr(`SCSA_ADDR_TEN, 32'(k << 3), OK);
			wait_pk();
			wait_pk();
			t0 = cyc;
			wait_pk();
			chk("interval", 34'(cyc - t0), 34'(iv[k]));
		end
		wr(`SCSA_ADDR_TEN, 32'h0, OK);
		repeat (2) @(negedge clk_sys);
		t0 = pk_cnt;
		repeat (150) @(negedge clk_sys);
		chk("off", 34'(pk_cnt - t0), 34'h0);
		@(posedge clk_sys);
		evs <= 6'h00;
		$display("test interval done");
		for (k = 0; k < 2; k++) begin
			wr(`SCSA_ADDR_CSTP, 32'(k), OK);
			halt_mode = k[0];
			go = 1'b1;
			for (c = 0; c < 60 && in_suspend_request_n !== 1'b1; c++) @(negedge clk_sys);
			to(c == 60);
			@(negedge clk_sys);
			chk("ack", 34'h0, 34'(suspend_ack_n));
			chk("clk_en", 34'(k == 0 ? 3 : 0), 34'({mem_clk_en, disp_clk_en}));
			chk("stop_ok", 34'(k), 34'(system_clock_in_stop_ok));
			go = 1'b0;
			for (c = 0; c < 60 && suspend_ack_n !== 1'b1; c++) @(negedge clk_sys);
			to(c == 60);
			repeat (2) @(negedge clk_sys);
			chk("resume", 34'h7, 34'({suspend_ack_n, mem_clk_en, disp_clk_en}));
		end
		chk("fault", 34'h0, 34'(fault));
		chk("queues", 34'h0, 34'(rdq.size() + bq.size() + pq.size()));
		$display("test suspend done");
		report_and_stop();
	end
endmodule // scsa_top_test
`default_nettype wire
